// ### uab_autobaud.sv
// Auto-baud detector with a small receiver and an Avalon-MM register slave.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "uab_defines.svh"

module uab_autobaud #(
    parameter int DATA_BITS = 8
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [`UAB_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    input wire logic RECEIVE_LINE
);
    import uab_pkg::*;

    // The receiver shift register is one byte wide, so longer characters cannot be held.
    if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_bad_data_bits
        $error("DATA_BITS must lie between 5 and 8");
    end

    localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

    uab_state_s q, d;
    uab_rate_sel_s sel;
    logic base_tick;
    logic abd_tick;
    logic psc_clr;
    logic rx_rise;
    logic rx_fall;
    logic do_wr;
    logic do_rd;
    logic [15:0] div;
    logic [15:0] cnt;

    assign sel = '{wide: q.wide, high: q.high};

    // One prescaler serves both the count ticks and the receiver's base ticks.
    uab_prescaler u_psc (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .clr(psc_clr),
        .sel(sel),
        .base_tick(base_tick),
        .abd_tick(abd_tick)
    );

    function automatic logic [31:0] rd_mux(input uab_state_s s, input logic [`UAB_ADDR_W-1:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `UAB_OFF_CTRL: begin
                r[`UAB_CTRL_AUTOBAUD_ENABLE_BIT] = s.autobaud_enable_bit;
                r[`UAB_CTRL_WIDE] = s.wide;
                r[`UAB_CTRL_HIGH] = s.high;
                r[`UAB_CTRL_WUE] = s.wake_on_break_enable;
            end
            `UAB_OFF_DIV_LO: begin
                r = s.div_lo;
            end
            `UAB_OFF_DIV_HI: begin
                r = s.div_hi;
            end
            `UAB_OFF_RXDATA: begin
                r = s.rx_data;
            end
            `UAB_OFF_STATUS: begin
                r[`UAB_STS_W-1:0] = s.sts;
            end
            `UAB_OFF_MASK: begin
                r[`UAB_STS_W-1:0] = s.mask;
            end
            `UAB_OFF_INFO: begin
                r[`UAB_INFO_RCIF] = s.rcif;
                r[`UAB_INFO_ABD_BUSY] = s.autobaud_enable_bit;
                r[`UAB_INFO_RX_IDLE] = (s.rx == RX_IDLE);
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return {24'h000000, r};
    endfunction

    always_comb begin
        d = q;
        psc_clr = 1'b0;
        cnt = {q.div_hi, q.div_lo};
        div = q.wide ? {q.div_hi, q.div_lo} : {8'h00, q.div_lo};
        rx_rise = RECEIVE_LINE && !q.rx_prev;
        rx_fall = !RECEIVE_LINE && q.rx_prev;
        d.rx_prev = RECEIVE_LINE;

        // One wait cycle per access, so read data is registered before it is sampled.
        do_wr = AVS_WRITE && !q.wreq && AVS_BYTEENABLE[0];
        do_rd = AVS_READ && !q.wreq;
        if ((AVS_READ || AVS_WRITE) && q.wreq) begin
            d.wreq = 1'b0;
            d.rdata = rd_mux(q, AVS_ADDRESS);
        end else begin
            d.wreq = 1'b1;
        end

        if (do_rd && AVS_ADDRESS == `UAB_OFF_RXDATA) begin
            d.rcif = 1'b0;
        end
        if (do_wr) begin
            case (AVS_ADDRESS)
                `UAB_OFF_CTRL: begin
                    d.autobaud_enable_bit = AVS_WRITEDATA[`UAB_CTRL_AUTOBAUD_ENABLE_BIT];
                    d.wide = AVS_WRITEDATA[`UAB_CTRL_WIDE];
                    d.high = AVS_WRITEDATA[`UAB_CTRL_HIGH];
                    d.wake_on_break_enable = AVS_WRITEDATA[`UAB_CTRL_WUE];
                    if (!AVS_WRITEDATA[`UAB_CTRL_AUTOBAUD_ENABLE_BIT]) begin
                        d.abd = ABD_OFF;
                    end else if (!q.autobaud_enable_bit) begin
                        // A repeated enable while busy leaves the running measurement alone.
                        if (AVS_WRITEDATA[`UAB_CTRL_WUE]) begin
                            d.abd = ABD_BRK_LOW;
                        end else begin
                            d.abd = ABD_START;
                        end
                    end
                end
                `UAB_OFF_DIV_LO: begin
                    if (!q.autobaud_enable_bit) begin
                        d.div_lo = AVS_WRITEDATA[7:0];
                    end
                end
                `UAB_OFF_DIV_HI: begin
                    if (!q.autobaud_enable_bit) begin
                        d.div_hi = AVS_WRITEDATA[7:0];
                    end
                end
                `UAB_OFF_STATUS: begin
                    d.sts = q.sts & ~AVS_WRITEDATA[`UAB_STS_W-1:0];
                end
                `UAB_OFF_MASK: begin
                    d.mask = AVS_WRITEDATA[`UAB_STS_W-1:0];
                end
                default: begin
                    d.sts = d.sts;
                end
            endcase
        end

        // Hardware events come after software clears so that a set always wins.
        case (q.abd)
            ABD_OFF: begin
                d.edges = q.edges;
            end
            ABD_BRK_LOW: begin
                if (rx_fall) begin
                    d.abd = ABD_BRK_HIGH;
                end
            end
            ABD_BRK_HIGH: begin
                if (rx_rise) begin
                    d.abd = ABD_START;
                end
            end
            ABD_START: begin
                if (rx_fall) begin
                    d.abd = ABD_EDGE1;
                end
            end
            ABD_EDGE1: begin
                if (rx_rise) begin
                    d.abd = ABD_COUNT;
                    {d.div_hi, d.div_lo} = `UAB_DIV_START;
                    d.edges = `UAB_FIRST_EDGE;
                    // Restarting the prescaler makes the first count tick a whole tick period long.
                    psc_clr = 1'b1;
                end
            end
            ABD_COUNT: begin
                if (abd_tick) begin
                    cnt = cnt + 16'h0001;
                    // A rate too slow for the selected clock wraps the count, so overflow is kept.
                    if ({q.div_hi, q.div_lo} == `UAB_DIV_MAX) begin
                        d.sts[`UAB_STS_ABD_OVF] = 1'b1;
                    end
                end
                {d.div_hi, d.div_lo} = cnt;
                if (rx_rise) begin
                    d.edges = q.edges + 3'h1;
                    if (q.edges == `UAB_LAST_EDGE) begin
                        d.abd = ABD_OFF;
                        d.autobaud_enable_bit = 1'b0;
                        d.rcif = 1'b1;
                        d.sts[`UAB_STS_ABD_DONE] = 1'b1;
                    end
                end
            end
            default: begin
                d.abd = ABD_OFF;
            end
        endcase

        // The receiver is parked while calibration runs and uses the divisor afterwards.
        if (q.autobaud_enable_bit) begin
            d.rx = RX_IDLE;
        end else begin
            case (q.rx)
                RX_IDLE: begin
                    if (rx_fall) begin
                        d.rx = RX_START;
                        d.tcnt = '0;
                    end
                end
                RX_START: begin
                    if (base_tick) begin
                        if (q.tcnt == (div >> 1)) begin
                            // A start bit that is high again at its middle was a glitch.
                            if (RECEIVE_LINE) begin
                                d.rx = RX_IDLE;
                            end else begin
                                d.rx = RX_DATA;
                            end
                            d.tcnt = '0;
                            d.bitn = '0;
                        end else begin
                            d.tcnt = q.tcnt + 16'h0001;
                        end
                    end
                end
                RX_DATA: begin
                    if (base_tick) begin
                        if (q.tcnt == div) begin
                            d.tcnt = '0;
                            // Sampling from a free-running prescaler costs up to one base tick of jitter.
                            d.shift = {RECEIVE_LINE, q.shift[7:1]};
                            d.bitn = q.bitn + 4'h1;
                            if (q.bitn == LAST_BIT) begin
                                d.rx = RX_STOP;
                            end
                        end else begin
                            d.tcnt = q.tcnt + 16'h0001;
                        end
                    end
                end
                RX_STOP: begin
                    if (base_tick) begin
                        if (q.tcnt == div) begin
                            d.rx = RX_IDLE;
                            // A low stop bit is a framing error and the byte is dropped.
                            if (RECEIVE_LINE) begin
                                d.rx_data = q.shift >> (8 - DATA_BITS);
                                d.rcif = 1'b1;
                                d.sts[`UAB_STS_RX_DONE] = 1'b1;
                            end
                        end else begin
                            d.tcnt = q.tcnt + 16'h0001;
                        end
                    end
                end
                default: begin
                    d.rx = RX_IDLE;
                end
            endcase
        end

        // The interrupt follows the next state, so it rises with its status bit.
        d.irq = |(d.sts & d.mask);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            q <= '0;
            q.wreq <= 1'b1;
            // The line idles high, so a low previous sample would fake a rising edge after reset.
            q.rx_prev <= 1'b1;
            q.abd <= ABD_OFF;
            q.rx <= RX_IDLE;
            {q.div_hi, q.div_lo} <= `UAB_DIV_RESET;
        end else begin
            q <= d;
        end
    end

    assign AVS_READDATA = q.rdata;
    assign AVS_WAITREQUEST = q.wreq;
    assign IRQ = q.irq;

endmodule
`default_nettype wire

// ### uab_defines.svh
// Constants for the auto-baud detect block: register map, field positions and rates.
`ifndef UAB_DEFINES_SVH
`define UAB_DEFINES_SVH

`define UAB_ADDR_W 5
`define UAB_OFF_CTRL 5'h00
`define UAB_OFF_DIV_LO 5'h04
`define UAB_OFF_DIV_HI 5'h08
`define UAB_OFF_RXDATA 5'h0c
`define UAB_OFF_STATUS 5'h10
`define UAB_OFF_MASK 5'h14
`define UAB_OFF_INFO 5'h18

`define UAB_CTRL_AUTOBAUD_ENABLE_BIT 0
`define UAB_CTRL_WIDE 1
`define UAB_CTRL_HIGH 2
`define UAB_CTRL_WUE 3

`define UAB_STS_W 3
`define UAB_STS_ABD_DONE 0
`define UAB_STS_RX_DONE 1
`define UAB_STS_ABD_OVF 2

`define UAB_INFO_RCIF 0
`define UAB_INFO_ABD_BUSY 1
`define UAB_INFO_RX_IDLE 2

`define UAB_PSC_W 9
`define UAB_BASE_M_SLOW 9'h03f
`define UAB_BASE_M_MID 9'h00f
`define UAB_BASE_M_FAST 9'h003
`define UAB_ABD_M_SLOW 9'h1ff
`define UAB_ABD_M_MID 9'h07f
`define UAB_ABD_M_FAST 9'h01f

`define UAB_DIV_RESET 16'h0000
`define UAB_DIV_START 16'h0001
`define UAB_DIV_MAX 16'hffff
`define UAB_FIRST_EDGE 3'h1
`define UAB_LAST_EDGE 3'h4

`endif

// ### uab_pkg.sv
// Types shared by the auto-baud detect block and its rate prescaler.
package uab_pkg;

    typedef struct packed {
        logic wide;
        logic high;
    } uab_rate_sel_s;

    typedef enum logic [2:0] {
        ABD_OFF = 3'b000,
        ABD_BRK_LOW = 3'b001,
        ABD_BRK_HIGH = 3'b010,
        ABD_START = 3'b011,
        ABD_EDGE1 = 3'b100,
        ABD_COUNT = 3'b101
    } uab_abd_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } uab_rx_e;

    typedef struct packed {
        logic [8:0] cnt;
    } uab_psc_s;

    typedef struct packed {
        logic wreq;
        logic [31:0] rdata;
        logic irq;
        logic autobaud_enable_bit;
        logic wide;
        logic high;
        logic wake_on_break_enable;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] rx_data;
        logic rcif;
        logic [2:0] sts;
        logic [2:0] mask;
        logic rx_prev;
        uab_abd_e abd;
        logic [2:0] edges;
        uab_rx_e rx;
        logic [15:0] tcnt;
        logic [3:0] bitn;
        logic [7:0] shift;
    } uab_state_s;

endpackage

// ### uab_prescaler.sv
// Divides the core clock into the baud base tick and the eight times slower auto-baud tick.
`timescale 1ns/10ps
`default_nettype none
`include "uab_defines.svh"

module uab_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire uab_pkg::uab_rate_sel_s sel,
    output logic base_tick,
    output logic abd_tick
);
    import uab_pkg::*;

    uab_psc_s q, d;
    logic [`UAB_PSC_W-1:0] base_m;
    logic [`UAB_PSC_W-1:0] abd_m;

    always_comb begin
        d = q;
        if (sel.wide && sel.high) begin
            base_m = `UAB_BASE_M_FAST;
            abd_m = `UAB_ABD_M_FAST;
        end else if (sel.wide || sel.high) begin
            base_m = `UAB_BASE_M_MID;
            abd_m = `UAB_ABD_M_MID;
        end else begin
            base_m = `UAB_BASE_M_SLOW;
            abd_m = `UAB_ABD_M_SLOW;
        end
        base_tick = (q.cnt & base_m) == base_m;
        abd_tick = (q.cnt & abd_m) == abd_m;
        // Restarting on the first measured edge aligns the tick phase with it.
        if (clr) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

// ### uab_autobaud_checker.sv
// Assertion checker for the auto-baud detect block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
`include "uab_defines.svh"
module uab_autobaud_checker (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [`UAB_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic IRQ,
    input wire logic RECEIVE_LINE
);
    logic acc;
    logic rdc;
    logic rise;
    logic cal_q;
    logic rx_q;
    logic [2:0] edg_q;
    logic [3:0] age_q;
    logic [2:0] msk_q;
    assign acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    assign rdc = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `UAB_OFF_CTRL;
    assign rise = RECEIVE_LINE && !rx_q;
    // Break framing is not modelled, so the edge-count checks are armed only without wake enable.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cal_q <= 1'b0;
            rx_q <= 1'b1;
            edg_q <= 3'h0;
            age_q <= 4'h0;
            msk_q <= 3'h0;
        end else begin
            rx_q <= RECEIVE_LINE;
            if (acc && AVS_ADDRESS == `UAB_OFF_MASK) begin
                msk_q <= AVS_WRITEDATA[2:0];
            end
            if (acc && AVS_ADDRESS == `UAB_OFF_CTRL) begin
                cal_q <= AVS_WRITEDATA[0] && !AVS_WRITEDATA[3];
                edg_q <= 3'h0;
                age_q <= 4'h0;
            end else if (edg_q != 3'h5) begin
                edg_q <= edg_q + {2'h0, rise};
            end else if (age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    property p_ack;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_ack: assert property (p_ack) else $error("Request not answered");
    property p_ack1;
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_ack1: assert property (p_ack1) else $error("Answer too long");
    property p_hi0;
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0;
    endproperty
    a_hi0: assert property (p_hi0) else $error("Upper read bits set");
    property p_rst;
        $fell(SYS_RST) |-> AVS_WAITREQUEST && !IRQ && AVS_READDATA == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("Bad reset outputs");
    property p_busy;
        rdc && cal_q && edg_q < 3'h5 |-> AVS_READDATA[0];
    endproperty
    a_busy: assert property (p_busy) else $error("Enable dropped early");
    property p_clr;
        rdc && cal_q && edg_q == 3'h5 && age_q > 4'h3 |-> !AVS_READDATA[0];
    endproperty
    a_clr: assert property (p_clr) else $error("Enable not cleared");
    property p_irq;
        cal_q && edg_q == 3'h4 && rise && msk_q[0] |-> ##[1:4] IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("No interrupt at fifth edge");
    property p_msk;
        msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !IRQ;
    endproperty
    a_msk: assert property (p_msk) else $error("Masked interrupt seen");
endmodule
bind uab_autobaud uab_autobaud_checker uab_autobaud_checker_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IRQ(IRQ), .RECEIVE_LINE(RECEIVE_LINE));
`default_nettype wire

// ### uab_sync_tx.sv
// Remote serial transmitter model that sends characters and breaks.
`timescale 1ns/10ps
`default_nettype none
module uab_sync_tx (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // Start bit, eight bits first bit lowest, then a high stop bit; the line then idles high.
    task automatic frame(input logic [7:0] b, input int per);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            line <= f[i];
            repeat (per - 1) @(posedge clk);
        end
    endtask
    task automatic brk(input int per);
        @(posedge clk);
        line <= 1'b0;
        repeat (12 * per) @(posedge clk);
        line <= 1'b1;
        repeat (2 * per) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### tb_uab_autobaud.sv
// Self-checking testbench for the auto-baud detect block.
`timescale 1ns/10ps
`default_nettype none
`include "uab_defines.svh"
module tb_uab_autobaud;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] ad = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wq;
    logic irq;
    logic line;
    int bad_count = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    uab_autobaud uab_autobaud_i (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(ad), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wq), .IRQ(irq), .RECEIVE_LINE(line));
    uab_sync_tx uab_sync_tx_i (.clk(clk), .line(line));
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // The request is held until the rising edge at which waitrequest is seen low, where data is taken.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        ad <= a;
        wd <= {24'h0, d};
        @(posedge clk);
        while (wq !== 1'b0) begin
            n++;
            if (n > 50) begin
                bad_count++;
                $display("Error waitrequest expected 0 seen 1");
                give_verdict();
            end
            @(posedge clk);
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic t_cal(input logic [3:0] c, input int per, input int adiv);
        logic [15:0] div;
        bus(1'b1, `UAB_OFF_MASK, 8'h01);
        bus(1'b1, `UAB_OFF_CTRL, {4'h0, c});
        bus(1'b0, `UAB_OFF_INFO, 8'h00);
        chk("busy", {15'h0, q[1]}, 16'h0001);
        bus(1'b0, `UAB_OFF_CTRL, 8'h00);
        chk("enable set", {15'h0, q[0]}, 16'h0001);
        if (c[3]) begin
            uab_sync_tx_i.brk(per);
        end
        uab_sync_tx_i.frame(8'h55, per);
        chk("irq", {15'h0, irq}, 16'h0001);
        bus(1'b0, `UAB_OFF_CTRL, 8'h00);
        chk("enable", {15'h0, q[0]}, 16'h0000);
        bus(1'b0, `UAB_OFF_DIV_LO, 8'h00);
        div[7:0] = q[7:0];
        bus(1'b0, `UAB_OFF_DIV_HI, 8'h00);
        div[15:8] = q[7:0];
        chk("divisor", div, 16'(1 + 8 * per / adiv));
        bus(1'b0, `UAB_OFF_RXDATA, 8'h00);
        bus(1'b0, `UAB_OFF_INFO, 8'h00);
        chk("flag", {15'h0, q[0]}, 16'h0000);
        bus(1'b1, `UAB_OFF_STATUS, 8'h07);
        @(negedge clk);
        chk("irq clear", {15'h0, irq}, 16'h0000);
    endtask
    // The divisor is set to one below the bit period in base ticks before a byte is received.
    task automatic t_rx;
        bus(1'b1, `UAB_OFF_MASK, 8'h00);
        bus(1'b1, `UAB_OFF_CTRL, 8'h06);
        bus(1'b1, `UAB_OFF_DIV_LO, 8'h08);
        uab_sync_tx_i.frame(8'ha5, 36);
        bus(1'b0, `UAB_OFF_RXDATA, 8'h00);
        chk("rx byte", {8'h00, q[7:0]}, 16'h00a5);
        bus(1'b0, `UAB_OFF_STATUS, 8'h00);
        chk("rx status", {15'h0, q[1]}, 16'h0001);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        bus(1'b1, `UAB_OFF_MASK, 8'h02);
        @(negedge clk);
        chk("irq on", {15'h0, irq}, 16'h0001);
        bus(1'b1, `UAB_OFF_STATUS, 8'h02);
        @(negedge clk);
        chk("irq off", {15'h0, irq}, 16'h0000);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 5'h1c, 8'h00);
        chk("unmapped", q[15:0], 16'h0000);
        t_cal(4'h1, 512, 512);
        t_cal(4'h5, 4224, 128);
        t_cal(4'h3, 128, 128);
        t_cal(4'h7, 32, 32);
        t_cal(4'hf, 32, 32);
        t_rx();
        give_verdict();
    end
endmodule
`default_nettype wire
